// File: debug_tap_pkg.sv
package debug_tap_pkg;

	// Register map (byte addresses on the plain register port)
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CONTROL = 8'h04;
	localparam logic [7:0] REG_COMMS_TX = 8'h08;
	localparam logic [7:0] REG_COMMS_RX = 8'h0C;
	localparam logic [7:0] REG_WATCH_BASE = 8'h20;
	localparam logic [7:0] REG_WATCH_STRIDE = 8'h20;
	localparam logic [4:0] WP_ADDR = 5'h00;
	localparam logic [4:0] WP_ADDR_MASK = 5'h04;
	localparam logic [4:0] WP_DATA = 5'h08;
	localparam logic [4:0] WP_DATA_MASK = 5'h0C;
	localparam logic [4:0] WP_CTRL = 5'h10;
	localparam int WATCH_UNITS = 2;

	// Control register bit
	localparam int CTRL_RESTART_BIT = 0;

	// Watchpoint control fields: value [3:0], ignore mask [7:4], enable [8]
	localparam int WPC_MASK_LSB = 4;
	localparam int WPC_ENABLE_BIT = 8;

	// TAP instructions
	localparam logic [3:0] INSTR_EXTEST = 4'h0;
	localparam logic [3:0] INSTR_SCAN_N = 4'h2;
	localparam logic [3:0] INSTR_RESTART = 4'h4;
	localparam logic [3:0] INSTR_INTEST = 4'hC;
	localparam logic [3:0] INSTR_IDCODE = 4'hE;
	localparam logic [3:0] INSTR_BYPASS = 4'hF;
	localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;

	// Scan chain identifiers
	localparam logic [3:0] CHAIN_EXTERNAL = 4'h0;
	localparam logic [3:0] CHAIN_COMMS = 4'h2;

	// Data register lengths
	localparam int DR_W = 33;
	localparam int LEN_BYPASS = 1;
	localparam int LEN_SCAN_N = 4;
	localparam int LEN_IDCODE = 32;
	localparam int LEN_COMMS = 33;

	// Synchronised pin positions
	localparam int PIN_TCK = 0;
	localparam int PIN_TMS = 1;
	localparam int PIN_TDI = 2;
	localparam int PIN_TRST_N = 3;
	localparam int PIN_TCK_EN = 4;
	localparam int PIN_RETURN = 5;
	localparam int PIN_DBG_EN = 6;
	localparam int PIN_COUNT = 7;
	localparam logic [PIN_COUNT-1:0] PIN_RESET_VALUE = 7'h00;

	typedef enum logic [3:0] {
		TAP_EXIT2_DR = 4'h0, TAP_EXIT1_DR = 4'h1, TAP_SHIFT_DR = 4'h2, TAP_PAUSE_DR = 4'h3,
		TAP_SELECT_IR = 4'h4, TAP_UPDATE_DR = 4'h5, TAP_CAPTURE_DR = 4'h6, TAP_SELECT_DR = 4'h7,
		TAP_EXIT2_IR = 4'h8, TAP_EXIT1_IR = 4'h9, TAP_SHIFT_IR = 4'hA, TAP_PAUSE_IR = 4'hB,
		TAP_IDLE = 4'hC, TAP_UPDATE_IR = 4'hD, TAP_CAPTURE_IR = 4'hE, TAP_RESET = 4'hF
	} tap_state_t;

	typedef enum logic [1:0] {
		DBG_RUN = 2'b00,
		DBG_FETCH_PEND = 2'b01,
		DBG_DATA_PEND = 2'b10,
		DBG_HALTED = 2'b11
	} debug_state_t;

	typedef enum logic [2:0] {
		SEL_BYPASS = 3'b000,
		SEL_IDCODE = 3'b001,
		SEL_SCAN_N = 3'b010,
		SEL_COMMS = 3'b011,
		SEL_EXTERNAL = 3'b100
	} dr_sel_t;

	// Core access presented to the watchpoint comparators
	typedef struct packed {
		logic [31:0] address;
		logic [31:0] data;
		logic write;
		logic fetch;
		logic valid;
	} core_access_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] addr_mask;
		logic [31:0] data;
		logic [31:0] data_mask;
		logic [3:0] ctrl_value;
		logic [3:0] ctrl_mask;
		logic enable;
	} watch_t;

	localparam watch_t WATCH_RESET = '0;

endpackage

// File: debug_tap_sideband.sv
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps

module debug_tap_sideband
	import debug_tap_pkg::*;
#(
	// Arbitrary identification value
	parameter logic [31:0] TAP_ID_CODE = 32'h1234_5677
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clock_enable,
	// Register port
	input wire logic [ADDR_W-1:0] reg_address,
	input wire logic [31:0] reg_write_data,
	input wire logic reg_write_strobe,
	input wire logic reg_read_strobe,
	output logic [31:0] reg_read_data,
	// Core pipeline and bus
	input wire core_access_t core_access,
	input wire logic core_execute,
	input wire logic core_flush,
	input wire logic core_instr_done,
	// Debug sideband
	input wire logic external_breakpoint_in,
	input wire logic external_debug_request,
	input wire logic debug_feature_enable,
	input wire logic [1:0] external_condition,
	output logic debug_acknowledge,
	output logic comms_rx_full,
	output logic comms_tx_empty,
	output logic [1:0] watchpoint_range_match,
	// JTAG pins
	input wire logic test_clock,
	input wire logic test_clock_enable,
	input wire logic test_reset_n,
	input wire logic test_mode_select,
	input wire logic test_data_in,
	output logic test_data_out,
	output logic test_data_out_enable_n,
	// External scan chain
	output logic ext_chain_serial_out,
	input wire logic ext_chain_serial_return,
	// Scan chain mirrors and flags
	output logic [3:0] tap_instruction_mirror,
	output logic [3:0] scan_chain_select_mirror,
	output logic [3:0] tap_state_mirror,
	output logic capture_state_flag,
	output logic shift_state_flag,
	output logic update_state_flag,
	output logic intest_state_flag,
	output logic extest_state_flag
);

	typedef struct packed {
		logic [PIN_COUNT-1:0] meta;
		logic [PIN_COUNT-1:0] sync;
		logic tck_prev;
		tap_state_t tap;
		logic [3:0] ir;
		logic [3:0] ir_shift;
		logic [3:0] chain;
		logic [DR_W-1:0] dr;
		debug_state_t dbg;
		logic tx_full;
		logic [31:0] tx_data;
		logic rx_full;
		logic [31:0] rx_data;
		watch_t [WATCH_UNITS-1:0] wp;
		logic [31:0] rd_data;
		logic ack;
		logic rx_flag;
		logic tx_flag;
		logic [1:0] range;
		logic tdo;
		logic tdo_en_n;
		logic chain_out;
		logic [3:0] ir_mirror;
		logic [3:0] chain_mirror;
		logic [3:0] tap_mirror;
		logic cap_flag;
		logic shift_flag;
		logic upd_flag;
		logic intest_flag;
		logic extest_flag;
	} state_t;

	localparam state_t STATE_RESET = '{
		meta: PIN_RESET_VALUE, sync: PIN_RESET_VALUE, tap: TAP_RESET, ir: INSTR_IDCODE,
		ir_mirror: INSTR_IDCODE, tap_mirror: TAP_RESET, dbg: DBG_RUN, tdo_en_n: 1'b1,
		tx_flag: 1'b1, wp: {WATCH_UNITS{WATCH_RESET}}, default: '0
	};

	state_t st;
	state_t next_st;

	logic [PIN_COUNT-1:0] pins;
	logic [WATCH_UNITS-1:0] match;
	logic [WATCH_UNITS-1:0] armed_hit;
	logic tck_rise;
	logic tck_fall;
	logic dbg_en;
	logic brk;
	logic restart_go;
	logic wp_sel;
	logic [0:0] wp_unit;
	logic [4:0] wp_off;
	dr_sel_t sel;
	int dr_len;
	tap_state_t tap_next;

	assign pins = {debug_feature_enable, ext_chain_serial_return, test_clock_enable,
		test_reset_n, test_data_in, test_mode_select, test_clock};

	// Comparators are combinational on the live core access
	for (genvar i = 0; i < WATCH_UNITS; i++) begin : g_watch
		assign match[i] = core_access.valid
			&& (((core_access.address ^ st.wp[i].addr) & ~st.wp[i].addr_mask) == 32'h0000_0000)
			&& (((core_access.data ^ st.wp[i].data) & ~st.wp[i].data_mask) == 32'h0000_0000)
			&& ((({external_condition, core_access.write, core_access.fetch}
				^ st.wp[i].ctrl_value) & ~st.wp[i].ctrl_mask) == 4'h0);
		assign armed_hit[i] = match[i] && st.wp[i].enable;
	end

	function automatic tap_state_t tap_step(input tap_state_t s, input logic tms);
		case (s)
			TAP_RESET: tap_step = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_step = tms ? TAP_SELECT_DR : TAP_IDLE;
			TAP_SELECT_DR: tap_step = tms ? TAP_SELECT_IR : TAP_CAPTURE_DR;
			TAP_CAPTURE_DR: tap_step = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: tap_step = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: tap_step = tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tap_step = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: tap_step = tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
			TAP_UPDATE_DR: tap_step = tms ? TAP_SELECT_DR : TAP_IDLE;
			TAP_SELECT_IR: tap_step = tms ? TAP_RESET : TAP_CAPTURE_IR;
			TAP_CAPTURE_IR: tap_step = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: tap_step = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: tap_step = tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tap_step = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: tap_step = tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
			TAP_UPDATE_IR: tap_step = tms ? TAP_SELECT_DR : TAP_IDLE;
			default: tap_step = TAP_RESET;
		endcase
	endfunction

	always_comb begin
		next_st = st;
		// Two-stage pin synchronisers; edges are found on the second stage only
		next_st.meta = pins;
		next_st.sync = st.meta;
		next_st.tck_prev = st.sync[PIN_TCK];
		dbg_en = st.sync[PIN_DBG_EN];
		tck_rise = st.sync[PIN_TCK] && !st.tck_prev && st.sync[PIN_TCK_EN];
		tck_fall = !st.sync[PIN_TCK] && st.tck_prev && st.sync[PIN_TCK_EN];
		restart_go = 1'b0;
		tap_next = tap_step(st.tap, st.sync[PIN_TMS]);

		// Data register routing follows instruction and chain
		case (st.ir)
			INSTR_IDCODE: sel = SEL_IDCODE;
			INSTR_SCAN_N: sel = SEL_SCAN_N;
			INSTR_INTEST, INSTR_EXTEST: begin
				if (st.chain == CHAIN_COMMS) begin
					sel = SEL_COMMS;
				end else if (st.chain == CHAIN_EXTERNAL) begin
					sel = SEL_EXTERNAL;
				end else begin
					sel = SEL_BYPASS;
				end
			end
			default: sel = SEL_BYPASS;
		endcase
		case (sel)
			SEL_IDCODE: dr_len = LEN_IDCODE;
			SEL_SCAN_N: dr_len = LEN_SCAN_N;
			SEL_COMMS: dr_len = LEN_COMMS;
			default: dr_len = LEN_BYPASS;
		endcase

		// TAP rising edge: capture, shift, advance
		if (tck_rise) begin
			case (st.tap)
				TAP_CAPTURE_IR: next_st.ir_shift = IR_CAPTURE_VALUE;
				TAP_SHIFT_IR: next_st.ir_shift = {st.sync[PIN_TDI], st.ir_shift[3:1]};
				TAP_CAPTURE_DR: begin
					case (sel)
						SEL_IDCODE: next_st.dr = {1'b0, TAP_ID_CODE};
						SEL_SCAN_N: next_st.dr = {29'h0000_0000, st.chain};
						SEL_COMMS: begin
							// Debugger takes the transmit word; buffer is empty afterwards
							next_st.dr = {st.tx_full, st.tx_data};
							next_st.tx_full = 1'b0;
						end
						default: next_st.dr = '0;
					endcase
				end
				TAP_SHIFT_DR: begin
					next_st.dr = st.dr >> 1;
					next_st.dr[dr_len-1] = st.sync[PIN_TDI];
				end
				default: begin
				end
			endcase
			if (tap_next == TAP_IDLE && st.tap != TAP_IDLE && st.ir == INSTR_RESTART) begin
				restart_go = 1'b1;
			end
			next_st.tap = tap_next;
		end

		// TAP falling edge: drive test data out, apply updates
		if (tck_fall) begin
			if (st.tap == TAP_SHIFT_IR) begin
				next_st.tdo = st.ir_shift[0];
				next_st.tdo_en_n = 1'b0;
			end else if (st.tap == TAP_SHIFT_DR) begin
				next_st.tdo = (sel == SEL_EXTERNAL) ? st.sync[PIN_RETURN] : st.dr[0];
				next_st.tdo_en_n = 1'b0;
			end else begin
				next_st.tdo_en_n = 1'b1;
			end
			case (st.tap)
				TAP_RESET: next_st.ir = INSTR_IDCODE;
				TAP_UPDATE_IR: next_st.ir = st.ir_shift;
				TAP_UPDATE_DR: begin
					if (sel == SEL_SCAN_N) begin
						next_st.chain = st.dr[3:0];
					end
					if (sel == SEL_COMMS && st.dr[DR_W-1]) begin
						next_st.rx_data = st.dr[31:0];
						next_st.rx_full = 1'b1;
					end
					next_st.ir_mirror = st.ir;
					next_st.chain_mirror = next_st.chain;
				end
				default: begin
				end
			endcase
		end

		// Register port
		wp_sel = reg_address >= REG_WATCH_BASE
			&& reg_address < REG_WATCH_BASE + REG_WATCH_STRIDE + REG_WATCH_STRIDE;
		wp_unit = 1'(reg_address[5] ^ REG_WATCH_BASE[5]);
		wp_off = reg_address[4:0];
		next_st.rd_data = 32'h0000_0000;
		if (reg_read_strobe) begin
			case (reg_address)
				REG_STATUS: next_st.rd_data = {14'h0000, st.range, st.chain, st.ir, st.tap,
					dbg_en, st.tx_flag, st.rx_flag, st.ack};
				REG_COMMS_RX: begin
					next_st.rd_data = st.rx_data;
					next_st.rx_full = 1'b0;
				end
				default: begin
					if (wp_sel) begin
						case (wp_off)
							WP_ADDR: next_st.rd_data = st.wp[wp_unit].addr;
							WP_ADDR_MASK: next_st.rd_data = st.wp[wp_unit].addr_mask;
							WP_DATA: next_st.rd_data = st.wp[wp_unit].data;
							WP_DATA_MASK: next_st.rd_data = st.wp[wp_unit].data_mask;
							WP_CTRL: next_st.rd_data = {23'h00_0000, st.wp[wp_unit].enable,
								st.wp[wp_unit].ctrl_mask, st.wp[wp_unit].ctrl_value};
							default: next_st.rd_data = 32'h0000_0000;
						endcase
					end
				end
			endcase
		end
		// Receive set from the TAP beats a same-cycle core read
		if (tck_fall && st.tap == TAP_UPDATE_DR && sel == SEL_COMMS && st.dr[DR_W-1]) begin
			next_st.rx_full = 1'b1;
		end
		if (reg_write_strobe) begin
			case (reg_address)
				REG_CONTROL: restart_go = restart_go || reg_write_data[CTRL_RESTART_BIT];
				REG_COMMS_TX: begin
					// Core write beats a same-cycle capture by the debugger
					next_st.tx_data = reg_write_data;
					next_st.tx_full = 1'b1;
				end
				default: begin
					if (wp_sel) begin
						case (wp_off)
							WP_ADDR: next_st.wp[wp_unit].addr = reg_write_data;
							WP_ADDR_MASK: next_st.wp[wp_unit].addr_mask = reg_write_data;
							WP_DATA: next_st.wp[wp_unit].data = reg_write_data;
							WP_DATA_MASK: next_st.wp[wp_unit].data_mask = reg_write_data;
							WP_CTRL: begin
								next_st.wp[wp_unit].ctrl_value = reg_write_data[3:0];
								next_st.wp[wp_unit].ctrl_mask = reg_write_data[WPC_MASK_LSB +: 4];
								next_st.wp[wp_unit].enable = reg_write_data[WPC_ENABLE_BIT];
							end
							default: begin
							end
						endcase
					end
				end
			endcase
		end

		// Debug entry and exit
		brk = external_breakpoint_in || (|armed_hit);
		case (st.dbg)
			DBG_RUN: begin
				if (external_debug_request || (brk && core_access.valid && !core_access.fetch)) begin
					next_st.dbg = DBG_DATA_PEND;
				end else if (brk && core_access.valid && core_access.fetch) begin
					next_st.dbg = DBG_FETCH_PEND;
				end
			end
			DBG_FETCH_PEND: begin
				if (core_execute) begin
					next_st.dbg = DBG_HALTED;
				end else if (external_debug_request
					|| (brk && core_access.valid && !core_access.fetch)) begin
					next_st.dbg = DBG_DATA_PEND;
				end else if (core_flush) begin
					next_st.dbg = DBG_RUN;
				end
			end
			DBG_DATA_PEND: begin
				if (core_instr_done) begin
					next_st.dbg = DBG_HALTED;
				end
			end
			DBG_HALTED: begin
				if (restart_go) begin
					next_st.dbg = DBG_RUN;
				end
			end
			default: next_st.dbg = DBG_RUN;
		endcase
		// With debug disabled nothing can halt the core
		if (!dbg_en) begin
			next_st.dbg = DBG_RUN;
		end

		// Test reset holds the whole JTAG side; core-side comms words survive
		if (!st.sync[PIN_TRST_N]) begin
			next_st.tap = TAP_RESET;
			next_st.ir = INSTR_IDCODE;
			next_st.ir_shift = '0;
			next_st.chain = CHAIN_EXTERNAL;
			next_st.dr = '0;
			next_st.tdo = 1'b0;
			next_st.tdo_en_n = 1'b1;
			next_st.ir_mirror = INSTR_IDCODE;
			next_st.chain_mirror = CHAIN_EXTERNAL;
		end

		// Registered outputs
		next_st.ack = next_st.dbg == DBG_HALTED;
		next_st.rx_flag = next_st.rx_full;
		next_st.tx_flag = !next_st.tx_full;
		next_st.range = dbg_en ? match : 2'b00;
		next_st.chain_out = st.sync[PIN_TDI];
		next_st.tap_mirror = next_st.tap;
		next_st.cap_flag = next_st.chain == CHAIN_EXTERNAL && next_st.tap == TAP_CAPTURE_DR;
		next_st.shift_flag = next_st.chain == CHAIN_EXTERNAL && next_st.tap == TAP_SHIFT_DR;
		next_st.upd_flag = next_st.chain == CHAIN_EXTERNAL && next_st.tap == TAP_UPDATE_DR;
		next_st.intest_flag = next_st.chain == CHAIN_EXTERNAL && next_st.ir == INSTR_INTEST;
		next_st.extest_flag = next_st.chain == CHAIN_EXTERNAL && next_st.ir == INSTR_EXTEST;

		if (!clock_enable) begin
			next_st = st;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st <= STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign reg_read_data = st.rd_data;
	assign debug_acknowledge = st.ack;
	assign comms_rx_full = st.rx_flag;
	assign comms_tx_empty = st.tx_flag;
	assign watchpoint_range_match = st.range;
	assign test_data_out = st.tdo;
	assign test_data_out_enable_n = st.tdo_en_n;
	assign ext_chain_serial_out = st.chain_out;
	assign tap_instruction_mirror = st.ir_mirror;
	assign scan_chain_select_mirror = st.chain_mirror;
	assign tap_state_mirror = st.tap_mirror;
	assign capture_state_flag = st.cap_flag;
	assign shift_state_flag = st.shift_flag;
	assign update_state_flag = st.upd_flag;
	assign intest_state_flag = st.intest_flag;
	assign extest_state_flag = st.extest_flag;

endmodule // debug_tap_sideband

// File: debug_tap_chk.sv
`timescale 1ns/1ps
module debug_tap_chk
	import debug_tap_pkg::*;
(
	// Clock and resets
	input wire logic clock,
	input wire logic reset_n,
	input wire logic test_reset_n,
	// Register port
	input wire logic [ADDR_W-1:0] reg_address,
	input wire logic [31:0] reg_write_data,
	input wire logic reg_write_strobe,
	// Core and sideband
	input wire logic core_execute,
	input wire logic core_instr_done,
	input wire logic debug_feature_enable,
	input wire logic debug_acknowledge,
	input wire logic comms_tx_empty,
	input wire logic [1:0] watchpoint_range_match,
	// JTAG side
	input wire logic test_clock,
	input wire logic test_data_in,
	input wire logic ext_chain_serial_out,
	input wire logic [3:0] tap_instruction_mirror,
	input wire logic [3:0] scan_chain_select_mirror,
	input wire logic [3:0] tap_state_mirror,
	input wire logic capture_state_flag,
	input wire logic shift_state_flag
);
	logic restart_wr;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	assign restart_wr = reg_write_strobe && reg_address == REG_CONTROL && reg_write_data[0];
	sequence s_restart;
		debug_acknowledge && restart_wr;
	endsequence
	sequence s_tx_write;
		reg_write_strobe && reg_address == REG_COMMS_TX;
	endsequence
	// Update-IR precedes the Idle entry that restarts the core
	a_ack_holds: assert property (debug_acknowledge && debug_feature_enable && !restart_wr
		&& tap_state_mirror != TAP_IDLE && tap_state_mirror != TAP_UPDATE_IR |=> debug_acknowledge)
		else $error("acknowledge dropped without restart");
	a_restart_drop: assert property (s_restart |=> ##[0:1] !debug_acknowledge)
		else $error("acknowledge stayed after restart");
	a_ack_cause: assert property ($rose(debug_acknowledge) |->
		$past(core_instr_done) || $past(core_execute)) else $error("halt without completion");
	a_enable_off: assert property (!debug_feature_enable [*4] |=>
		watchpoint_range_match == 2'b00 && !debug_acknowledge) else $error("debug active while off");
	a_tx_write: assert property (s_tx_write |=> !comms_tx_empty)
		else $error("transmit flag still empty after write");
	a_state_edge: assert property ($changed(tap_state_mirror) && test_reset_n |->
		$past(test_clock, 2) || $past(test_clock, 3) || $past(test_clock, 4))
		else $error("state mirror moved without test clock rise");
	a_chain_update: assert property ($changed(scan_chain_select_mirror) |->
		$past(tap_state_mirror) == TAP_UPDATE_DR || tap_state_mirror == TAP_RESET)
		else $error("chain mirror moved outside update");
	a_ir_update: assert property ($changed(tap_instruction_mirror) |->
		$past(tap_state_mirror) == TAP_UPDATE_DR || tap_state_mirror == TAP_RESET)
		else $error("instruction mirror moved outside update");
	a_flags_chain0: assert property (capture_state_flag || shift_state_flag |->
		scan_chain_select_mirror == CHAIN_EXTERNAL) else $error("state flag with other chain");
	a_capture_flag: assert property (tap_state_mirror == TAP_CAPTURE_DR
		&& scan_chain_select_mirror == CHAIN_EXTERNAL |-> capture_state_flag)
		else $error("capture flag missing");
	a_serial_out: assert property (ext_chain_serial_out == $past(test_data_in, 3))
		else $error("external chain data wrong");
endmodule // debug_tap_chk

bind debug_tap_sideband debug_tap_chk i_chk (.clock, .reset_n, .test_reset_n, .reg_address,
	.reg_write_data, .reg_write_strobe, .core_execute, .core_instr_done, .debug_feature_enable,
	.debug_acknowledge, .comms_tx_empty, .watchpoint_range_match, .test_clock, .test_data_in,
	.ext_chain_serial_out, .tap_instruction_mirror, .scan_chain_select_mirror, .tap_state_mirror,
	.capture_state_flag, .shift_state_flag);

// File: jtag_probe.sv
`timescale 1ns/1ps
module jtag_probe (
	// System clock and device pins
	input wire logic clock,
	input wire logic test_data_out,
	input wire logic ext_chain_serial_out,
	// Driven toward the device
	output logic test_clock,
	output logic test_mode_select,
	output logic test_data_in,
	output logic ext_chain_serial_return
);
	logic [3:0] chain = 4'h0;
	initial begin
		test_clock = 1'b0;
		test_mode_select = 1'b1;
		test_data_in = 1'b0;
	end
	// Four-stage external chain looped back to the device
	always @(posedge test_clock) begin
		chain <= {ext_chain_serial_out, chain[3:1]};
	end
	assign ext_chain_serial_return = chain[0];
	// Test clock stands low between calls; 5 cycles low, 3 high gives 200 ns
	task automatic tck(input logic m, input logic d, output logic q);
		test_mode_select <= m;
		test_data_in <= d;
		repeat (4) @(posedge clock);
		@(negedge clock);
		q = test_data_out;
		@(posedge clock);
		test_clock <= 1'b1;
		repeat (3) @(posedge clock);
		test_clock <= 1'b0;
	endtask
	// From Idle through one IR or DR scan, LSB first, back to Idle
	task automatic scan(input logic ir, input logic [32:0] din, input int n,
		output logic [32:0] dout);
		logic q;
		dout = '0;
		@(posedge clock);
		tck(1'b1, 1'b0, q);
		if (ir) begin
			tck(1'b1, 1'b0, q);
		end
		tck(1'b0, 1'b0, q);
		tck(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			tck(i == n - 1, din[i], q);
			dout[i] = q;
		end
		tck(1'b1, 1'b0, q);
		tck(1'b0, 1'b0, q);
	endtask
endmodule // jtag_probe

// File: testbench.sv
`timescale 1ns/1ps
module testbench
	import debug_tap_pkg::*;
;
	localparam logic [31:0] ID = 32'h2468_ACE1; // Arbitrary value
	localparam logic [7:0] WB = REG_WATCH_BASE;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_address = 8'h00;
	logic [31:0] reg_write_data = 32'h0000_0000;
	logic reg_write_strobe = 1'b0;
	logic reg_read_strobe = 1'b0;
	logic [31:0] reg_read_data;
	core_access_t core_access = '0;
	logic core_execute = 1'b0;
	logic core_flush = 1'b0;
	logic core_instr_done = 1'b0;
	logic external_breakpoint_in = 1'b0;
	logic external_debug_request = 1'b0;
	logic debug_feature_enable = 1'b1;
	logic [1:0] external_condition = 2'b00;
	logic test_reset_n = 1'b1;
	logic debug_acknowledge, comms_rx_full, comms_tx_empty, test_data_out, test_data_out_enable_n;
	logic [1:0] watchpoint_range_match;
	logic test_clock, test_mode_select, test_data_in, ext_chain_serial_out, ext_chain_serial_return;
	logic [3:0] tap_instruction_mirror, scan_chain_select_mirror, tap_state_mirror;
	logic capture_state_flag, shift_state_flag, update_state_flag;
	logic intest_state_flag, extest_state_flag, q;
	logic [32:0] d;
	int err_total = 0;
	int compares = 0;
	int cycles = 0;

	debug_tap_sideband #(.TAP_ID_CODE(ID)) i_dut (.clock(clock), .reset_n(reset_n),
		.clock_enable(1'b1), .reg_address(reg_address), .reg_write_data(reg_write_data),
		.reg_write_strobe(reg_write_strobe), .reg_read_strobe(reg_read_strobe),
		.reg_read_data(reg_read_data), .core_access(core_access), .core_execute(core_execute),
		.core_flush(core_flush), .core_instr_done(core_instr_done),
		.external_breakpoint_in(external_breakpoint_in),
		.external_debug_request(external_debug_request),
		.debug_feature_enable(debug_feature_enable), .external_condition(external_condition),
		.debug_acknowledge(debug_acknowledge), .comms_rx_full(comms_rx_full),
		.comms_tx_empty(comms_tx_empty), .watchpoint_range_match(watchpoint_range_match),
		.test_clock(test_clock), .test_clock_enable(1'b1), .test_reset_n(test_reset_n),
		.test_mode_select(test_mode_select), .test_data_in(test_data_in),
		.test_data_out(test_data_out), .test_data_out_enable_n(test_data_out_enable_n),
		.ext_chain_serial_out(ext_chain_serial_out),
		.ext_chain_serial_return(ext_chain_serial_return),
		.tap_instruction_mirror(tap_instruction_mirror),
		.scan_chain_select_mirror(scan_chain_select_mirror), .tap_state_mirror(tap_state_mirror),
		.capture_state_flag(capture_state_flag), .shift_state_flag(shift_state_flag),
		.update_state_flag(update_state_flag), .intest_state_flag(intest_state_flag),
		.extest_state_flag(extest_state_flag));
	jtag_probe i_probe (.clock(clock), .test_data_out(test_data_out),
		.ext_chain_serial_out(ext_chain_serial_out), .test_clock(test_clock),
		.test_mode_select(test_mode_select), .test_data_in(test_data_in),
		.ext_chain_serial_return(ext_chain_serial_return));

	initial begin
		forever #12.5 clock = ~clock;
	end
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		reg_write_strobe <= 1'b1;
		reg_address <= a;
		reg_write_data <= v;
		@(posedge clock);
		reg_write_strobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_read_strobe <= 1'b1;
		reg_address <= a;
		@(posedge clock);
		reg_read_strobe <= 1'b0;
		#1;
		check(reg_read_data, exp);
	endtask
	task automatic pulse(input logic [2:0] p);
		@(posedge clock);
		{core_instr_done, core_execute, core_flush} <= p;
		@(posedge clock);
		{core_instr_done, core_execute, core_flush} <= 3'b000;
	endtask
	task automatic brk(input logic f, input logic b, input logic [1:0] e, input logic [31:0] a);
		@(posedge clock);
		core_access <= '{a, 32'h0000_0000, 1'b0, f, 1'b1};
		external_breakpoint_in <= b;
		external_condition <= e;
		@(posedge clock);
		core_access <= '0;
		external_breakpoint_in <= 1'b0;
		#1;
	endtask
	task finish_test;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Whole run needs about 1300 cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			err_total++;
			finish_test();
		end
	end

	initial begin
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		cyc(4);
		check(test_data_out_enable_n, 1'b1);
		rd(REG_STATUS, 32'h0000_0EFC);
		rd(8'h14, 32'h0000_0000);
		$display("reset test done");
		i_probe.tck(1'b0, 1'b0, q);
		cyc(2);
		check(tap_state_mirror, TAP_IDLE);
		i_probe.scan(1'b0, 33'h0, 32, d);
		check(d[31:0], ID);
		i_probe.scan(1'b1, INSTR_SCAN_N, 4, d);
		check(d[3:0], IR_CAPTURE_VALUE);
		check(tap_instruction_mirror, INSTR_IDCODE);
		i_probe.scan(1'b0, CHAIN_COMMS, 4, d);
		check(d[3:0], CHAIN_EXTERNAL);
		check(scan_chain_select_mirror, CHAIN_COMMS);
		check(tap_instruction_mirror, INSTR_SCAN_N);
		i_probe.scan(1'b1, INSTR_INTEST, 4, d);
		$display("tap test done");
		wr(REG_COMMS_TX, 32'h1357_9BDF);
		cyc(1);
		check(comms_tx_empty, 1'b0);
		i_probe.scan(1'b0, {1'b1, 32'hA5A5_0F0F}, 33, d);
		check(d, {1'b1, 32'h1357_9BDF});
		check(comms_tx_empty, 1'b1);
		check(comms_rx_full, 1'b1);
		rd(REG_COMMS_RX, 32'hA5A5_0F0F);
		cyc(1);
		check(comms_rx_full, 1'b0);
		$display("comms test done");
		@(posedge clock);
		external_debug_request <= 1'b1;
		cyc(3);
		check(debug_acknowledge, 1'b0);
		pulse(3'b100);
		external_debug_request <= 1'b0;
		#1;
		check(debug_acknowledge, 1'b1);
		cyc(8);
		check(debug_acknowledge, 1'b1);
		wr(REG_CONTROL, 32'h0000_0001);
		cyc(2);
		check(debug_acknowledge, 1'b0);
		brk(1'b0, 1'b1, 2'b00, 32'h0000_0100);
		cyc(4);
		check(debug_acknowledge, 1'b0);
		pulse(3'b100);
		cyc(1);
		check(debug_acknowledge, 1'b1);
		i_probe.scan(1'b1, INSTR_RESTART, 4, d);
		cyc(4);
		check(debug_acknowledge, 1'b0);
		brk(1'b1, 1'b1, 2'b00, 32'h0000_0200);
		pulse(3'b100);
		pulse(3'b001);
		pulse(3'b010);
		cyc(2);
		check(debug_acknowledge, 1'b0);
		brk(1'b1, 1'b1, 2'b00, 32'h0000_0200);
		pulse(3'b010);
		cyc(1);
		check(debug_acknowledge, 1'b1);
		wr(REG_CONTROL, 32'h0000_0001);
		$display("halt test done");
		wr(WB + 8'(WP_ADDR), 32'h0000_4000);
		wr(WB + 8'(WP_ADDR_MASK), 32'h0000_0000);
		wr(WB + 8'(WP_DATA_MASK), 32'hFFFF_FFFF);
		wr(WB + 8'(WP_CTRL), 32'h0000_0078);
		for (int e = 0; e < 4; e++) begin
			brk(1'b0, 1'b0, 2'(e), 32'h0000_4000);
			check(watchpoint_range_match, {1'b0, e[1]});
		end
		check(debug_acknowledge, 1'b0);
		wr(WB + 8'(WP_CTRL), 32'h0000_0178);
		@(posedge clock);
		debug_feature_enable <= 1'b0;
		cyc(5);
		brk(1'b0, 1'b0, 2'b10, 32'h0000_4000);
		check(watchpoint_range_match, 2'b00);
		pulse(3'b100);
		cyc(1);
		check(debug_acknowledge, 1'b0);
		@(posedge clock);
		debug_feature_enable <= 1'b1;
		cyc(5);
		brk(1'b0, 1'b0, 2'b10, 32'h0000_4000);
		pulse(3'b100);
		cyc(1);
		check(debug_acknowledge, 1'b1);
		wr(REG_CONTROL, 32'h0000_0001);
		$display("watch test done");
		@(posedge clock);
		test_reset_n <= 1'b0;
		cyc(6);
		check({tap_state_mirror, tap_instruction_mirror}, {TAP_RESET, INSTR_IDCODE});
		check(scan_chain_select_mirror, CHAIN_EXTERNAL);
		check(test_data_out_enable_n, 1'b1);
		@(posedge clock);
		test_reset_n <= 1'b1;
		cyc(4);
		i_probe.tck(1'b0, 1'b0, q);
		i_probe.scan(1'b1, INSTR_EXTEST, 4, d);
		check({intest_state_flag, extest_state_flag}, 2'b01);
		i_probe.scan(1'b0, 33'hA5, 8, d);
		check(d, 33'h50);
		$display("test reset done");
		finish_test();
	end
endmodule // testbench
